// >>> scs_top.sv
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module scs_top import scs_pkg::*; #(
    parameter int EXT_KHZ = 25000
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_ext_beat,
    input  wire logic [1:0]  i_boot_pins,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic             o_sel_int,
    output logic             o_sel_ext,
    output logic             o_sel_pll,
    output logic             o_ext_osc_en,
    output logic             o_pll_en,
    output logic             o_pll_ref_ext,
    output logic      [3:0]  o_pll_mul,
    output logic      [3:0]  o_ahb_shift,
    output logic      [2:0]  o_apb1_shift,
    output logic      [2:0]  o_apb2_shift,
    output logic      [1:0]  o_flash_wait,
    output logic             o_prefetch_en,
    output logic      [1:0]  o_boot_sel,
    output logic             o_irq
);

    if (EXT_KHZ < EXT_MIN_KHZ || EXT_KHZ > EXT_MAX_KHZ) begin : g_bad_ext
        $error("EXT_KHZ outside the external source range");
    end

    scs_state_t       state_r,   state_nxt;
    scs_src_t         tgt_r,     tgt_nxt;
    logic [1:0]       gap_r,     gap_nxt;
    logic [7:0]       mon_cnt_r, mon_cnt_nxt;
    scs_ctrl_t        ctrl_r,    ctrl_nxt;
    scs_presc_t       presc_r,   presc_nxt;
    scs_flash_t       flash_r,   flash_nxt;
    logic [IRQ_W-1:0] istat_r,   istat_nxt;
    logic [IRQ_W-1:0] imask_r,   imask_nxt;
    logic [2:0]       sel_r,     sel_nxt;
    logic             irq_r;
    logic             wpend_r,   wpend_nxt;
    logic [7:0]       waddr_r,   waddr_nxt;
    logic [31:0]      hrdata_r,  hrdata_nxt;
    logic             hready_r,  hready_nxt;
    logic [2:0]       boot_cnt_r, boot_cnt_nxt;
    logic             boot_done_r, boot_done_nxt;
    logic [1:0]       boot_r,    boot_nxt;
    logic [2:0]       beat_s;
    logic [1:0]       boot_s1,   boot_s2;
    logic             beat_edge, ext_use, fail, acc;

    function automatic logic [31:0] sys_khz(input scs_ctrl_t c);
        logic [31:0] ref_khz;
        ref_khz = c.pll_ref_ext ? 32'(EXT_KHZ) : 32'(INT_KHZ / 2);
        case (c.src)
            SRC_EXT: sys_khz = 32'(EXT_KHZ);
            SRC_PLL: sys_khz = ref_khz * (32'(c.pll_mul) + 32'(PLL_MUL_OFS));
            default: sys_khz = 32'(INT_KHZ);
        endcase
    endfunction

    function automatic logic freq_ok(input scs_ctrl_t c, input scs_presc_t p);
        logic [31:0] ahb;
        ahb = sys_khz(c) >> p.ahb_sh;
        freq_ok = (c.src != 2'b11)
               && (c.src != SRC_EXT || c.ext_en)
               && (c.src != SRC_PLL || (c.pll_en && (!c.pll_ref_ext || c.ext_en)))
               && ahb <= 32'(AHB_MAX_KHZ)
               && (ahb >> p.apb2_sh) <= 32'(APB2_MAX_KHZ)
               && (ahb >> p.apb1_sh) <= 32'(APB1_MAX_KHZ);
    endfunction

    // Two-flop synchronisers; third beat stage only for edge detection
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            beat_s  <= 3'h0;
            boot_s1 <= 2'h0;
            boot_s2 <= 2'h0;
        end else begin
            beat_s  <= {beat_s[1:0], i_ext_beat};
            boot_s1 <= i_boot_pins;
            boot_s2 <= boot_s1;
        end
    end

    assign beat_edge = beat_s[2] ^ beat_s[1];
    assign ext_use   = (state_r != ST_INT) &&
                       (tgt_r == SRC_EXT || (tgt_r == SRC_PLL && ctrl_r.pll_ref_ext));
    assign fail      = ext_use && (mon_cnt_r == 8'(CSS_CYC));
    assign acc       = i_hsel && i_hready && i_htrans[1];

    always_comb begin
        state_nxt     = state_r;
        tgt_nxt       = tgt_r;
        gap_nxt       = gap_r;
        ctrl_nxt      = ctrl_r;
        presc_nxt     = presc_r;
        flash_nxt     = flash_r;
        istat_nxt     = istat_r;
        imask_nxt     = imask_r;
        wpend_nxt     = 1'b0;
        waddr_nxt     = waddr_r;
        hrdata_nxt    = hrdata_r;
        hready_nxt    = 1'b1;
        boot_cnt_nxt  = boot_cnt_r;
        boot_done_nxt = boot_done_r;
        boot_nxt      = boot_r;

        // Missing-beat watchdog on the external source
        if (!ext_use || beat_edge) begin
            mon_cnt_nxt = 8'h00;
        end else if (mon_cnt_r < 8'(CSS_CYC)) begin
            mon_cnt_nxt = mon_cnt_r + 8'h01;
        end else begin
            mon_cnt_nxt = mon_cnt_r;
        end

        // Bus: address phase
        if (acc && i_hwrite) begin
            wpend_nxt  = 1'b1;
            waddr_nxt  = i_haddr[7:0];
            hready_nxt = 1'b0;
        end else if (acc) begin
            case (i_haddr[7:0])
                A_CTRL:  hrdata_nxt = 32'(ctrl_r);
                A_PRESC: hrdata_nxt = 32'(presc_r);
                A_FLASH: hrdata_nxt = 32'(flash_r);
                A_STAT:  hrdata_nxt = 32'({boot_r, 1'b0, (mon_cnt_r == 8'h00), state_r == ST_GAP, tgt_r});
                A_ISTAT: hrdata_nxt = 32'(istat_r);
                A_IMASK: hrdata_nxt = 32'(imask_r);
                default: hrdata_nxt = 32'h0000_0000;
            endcase
        end

        // Bus: write data phase, one wait state
        if (wpend_r) begin
            case (waddr_r)
                A_CTRL: begin
                    if (freq_ok(scs_ctrl_t'(i_hwdata[8:0]), presc_r)) begin
                        ctrl_nxt = scs_ctrl_t'(i_hwdata[8:0]);
                    end else begin
                        istat_nxt[IRQ_PRESC] = 1'b1;
                    end
                end
                A_PRESC: begin
                    if (freq_ok(ctrl_r, scs_presc_t'(i_hwdata[9:0]))) begin
                        presc_nxt = scs_presc_t'(i_hwdata[9:0]);
                    end else begin
                        istat_nxt[IRQ_PRESC] = 1'b1;
                    end
                end
                A_FLASH: flash_nxt = scs_flash_t'(i_hwdata[2:0]);
                A_ISTAT: istat_nxt = istat_r & ~i_hwdata[IRQ_W-1:0];
                A_IMASK: imask_nxt = i_hwdata[IRQ_W-1:0];
                default: ;
            endcase
            if (waddr_r == A_ISTAT) begin
                istat_nxt[IRQ_PRESC] = istat_r[IRQ_PRESC] & ~i_hwdata[IRQ_PRESC];
            end
        end

        // Source switch: all selects off for the gap, then the target
        case (state_r)
            ST_INT, ST_EXT, ST_PLL: begin
                if (ctrl_r.src != tgt_r) begin
                    state_nxt = ST_GAP;
                    tgt_nxt   = scs_src_t'(ctrl_r.src);
                    gap_nxt   = 2'h0;
                end
            end
            ST_GAP: begin
                if (gap_r == 2'(GAP_CYC - 1)) begin
                    case (tgt_r)
                        SRC_EXT: state_nxt = ST_EXT;
                        SRC_PLL: state_nxt = ST_PLL;
                        default: state_nxt = ST_INT;
                    endcase
                end else begin
                    gap_nxt = gap_r + 2'h1;
                end
            end
            default: state_nxt = ST_INT;
        endcase

        // Failure: fall back to the internal oscillator; flag set wins over clear
        if (fail) begin
            state_nxt    = ST_GAP;
            tgt_nxt      = SRC_INT;
            gap_nxt      = 2'h0;
            ctrl_nxt.src = SRC_INT;
            mon_cnt_nxt  = 8'h00;
            if (tgt_r == SRC_EXT) begin
                istat_nxt[IRQ_EXT] = 1'b1;
            end else begin
                istat_nxt[IRQ_PLL] = 1'b1;
            end
        end

        sel_nxt = {state_nxt == ST_PLL, state_nxt == ST_EXT, state_nxt == ST_INT};

        // Boot pins caught once after settling
        if (!boot_done_r) begin
            if (boot_cnt_r == 3'(BOOT_CYC - 1)) begin
                boot_done_nxt = 1'b1;
                boot_nxt = !boot_s2[0] ? BOOT_FLASH : (boot_s2[1] ? BOOT_SRAM : BOOT_SYSMEM);
            end else begin
                boot_cnt_nxt = boot_cnt_r + 3'h1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r     <= ST_INT;
            tgt_r       <= SRC_INT;
            gap_r       <= 2'h0;
            mon_cnt_r   <= 8'h00;
            ctrl_r      <= CTRL_RST;
            presc_r     <= PRESC_RST;
            flash_r     <= FLASH_RST;
            istat_r     <= '0;
            imask_r     <= '0;
            sel_r       <= 3'b001;
            irq_r       <= 1'b0;
            wpend_r     <= 1'b0;
            waddr_r     <= 8'h00;
            hrdata_r    <= 32'h0000_0000;
            hready_r    <= 1'b1;
            boot_cnt_r  <= 3'h0;
            boot_done_r <= 1'b0;
            boot_r      <= BOOT_FLASH;
        end else begin
            state_r     <= state_nxt;
            tgt_r       <= tgt_nxt;
            gap_r       <= gap_nxt;
            mon_cnt_r   <= mon_cnt_nxt;
            ctrl_r      <= ctrl_nxt;
            presc_r     <= presc_nxt;
            flash_r     <= flash_nxt;
            istat_r     <= istat_nxt;
            imask_r     <= imask_nxt;
            sel_r       <= sel_nxt;
            irq_r       <= |(istat_nxt & imask_nxt);
            wpend_r     <= wpend_nxt;
            waddr_r     <= waddr_nxt;
            hrdata_r    <= hrdata_nxt;
            hready_r    <= hready_nxt;
            boot_cnt_r  <= boot_cnt_nxt;
            boot_done_r <= boot_done_nxt;
            boot_r      <= boot_nxt;
        end
    end

    assign o_hrdata      = hrdata_r;
    assign o_hreadyout   = hready_r;
    assign o_hresp       = 1'b0;
    assign o_sel_int     = sel_r[0];
    assign o_sel_ext     = sel_r[1];
    assign o_sel_pll     = sel_r[2];
    assign o_ext_osc_en  = ctrl_r.ext_en;
    assign o_pll_en      = ctrl_r.pll_en;
    assign o_pll_ref_ext = ctrl_r.pll_ref_ext;
    assign o_pll_mul     = ctrl_r.pll_mul;
    assign o_ahb_shift   = presc_r.ahb_sh;
    assign o_apb1_shift  = presc_r.apb1_sh;
    assign o_apb2_shift  = presc_r.apb2_sh;
    assign o_flash_wait  = flash_r.wait_st;
    assign o_prefetch_en = flash_r.prefetch;
    assign o_boot_sel    = boot_r;
    assign o_irq         = irq_r;

    property p_int_default;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (state_r == ST_INT) |-> (o_sel_int && !o_sel_ext && !o_sel_pll);
    endproperty
    a_int_default: assert property (p_int_default) else $error("internal source not selected");

    property p_mon_count;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (ext_use && !beat_edge && mon_cnt_r < 8'(CSS_CYC)) |=> (mon_cnt_r == $past(mon_cnt_r) + 8'h01);
    endproperty
    a_mon_count: assert property (p_mon_count) else $error("watchdog did not advance");

    property p_fallback;
        @(posedge i_core_clk) disable iff (!i_nrst)
        fail |=> (state_r == ST_GAP && !o_sel_int && !o_sel_ext && !o_sel_pll)[*3] ##1 o_sel_int;
    endproperty
    a_fallback: assert property (p_fallback) else $error("no fallback to internal source");

    property p_irq_fail;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (fail && tgt_r == SRC_EXT && imask_r[IRQ_EXT] && !wpend_r) |=> o_irq;
    endproperty
    a_irq_fail: assert property (p_irq_fail) else $error("enabled failure gave no interrupt");

    property p_pll_flag;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (fail && tgt_r == SRC_PLL) |=> istat_r[IRQ_PLL];
    endproperty
    a_pll_flag: assert property (p_pll_flag) else $error("pll reference failure not flagged");

    property p_ahb_limit;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (sys_khz(ctrl_r) >> presc_r.ahb_sh) <= 32'(AHB_MAX_KHZ);
    endproperty
    a_ahb_limit: assert property (p_ahb_limit) else $error("ahb clock above limit");

    property p_apb1_limit;
        @(posedge i_core_clk) disable iff (!i_nrst)
        ((sys_khz(ctrl_r) >> presc_r.ahb_sh) >> presc_r.apb1_sh) <= 32'(APB1_MAX_KHZ);
    endproperty
    a_apb1_limit: assert property (p_apb1_limit) else $error("low-speed clock above limit");

    property p_presc_load;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (wpend_r && waddr_r == A_PRESC && freq_ok(ctrl_r, scs_presc_t'(i_hwdata[9:0])))
            |=> (o_ahb_shift == $past(i_hwdata[3:0]) && o_apb1_shift == $past(i_hwdata[6:4]));
    endproperty
    a_presc_load: assert property (p_presc_load) else $error("prescaler write not applied");

    property p_boot_hold;
        @(posedge i_core_clk) disable iff (!i_nrst)
        boot_done_r |=> $stable(o_boot_sel) && boot_done_r;
    endproperty
    a_boot_hold: assert property (p_boot_hold) else $error("boot selection changed");

    property p_sticky;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (istat_r[IRQ_EXT] && !(wpend_r && waddr_r == A_ISTAT && i_hwdata[IRQ_EXT])) |=> istat_r[IRQ_EXT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("failure flag lost");

    property p_one_hot;
        @(posedge i_core_clk) disable iff (!i_nrst)
        $onehot0({o_sel_int, o_sel_ext, o_sel_pll});
    endproperty
    a_one_hot: assert property (p_one_hot) else $error("two sources selected");

endmodule // scs_top

// >>> scs_pkg.sv
package scs_pkg;
    // Register byte offsets
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_PRESC = 8'h04;
    localparam logic [7:0] A_FLASH = 8'h08;
    localparam logic [7:0] A_STAT  = 8'h0C;
    localparam logic [7:0] A_ISTAT = 8'h10;
    localparam logic [7:0] A_IMASK = 8'h14;

    typedef enum logic [1:0] {SRC_INT = 2'b00, SRC_EXT = 2'b01, SRC_PLL = 2'b10} scs_src_t;
    typedef enum logic [1:0] {ST_INT = 2'b00, ST_GAP = 2'b01, ST_EXT = 2'b11, ST_PLL = 2'b10} scs_state_t;

    // Control word, bits 8:0
    typedef struct packed {
        logic [3:0] pll_mul;
        logic       pll_ref_ext;
        logic       pll_en;
        logic       ext_en;
        logic [1:0] src;
    } scs_ctrl_t;

    // Prescaler word, bits 9:0, each field a right shift of its input clock
    typedef struct packed {
        logic [2:0] apb2_sh;
        logic [2:0] apb1_sh;
        logic [3:0] ahb_sh;
    } scs_presc_t;

    typedef struct packed {
        logic       prefetch;
        logic [1:0] wait_st;
    } scs_flash_t;

    localparam logic [8:0] CTRL_RST  = 9'h000;
    localparam logic [9:0] PRESC_RST = 10'h000;
    localparam logic [2:0] FLASH_RST = 3'h0;

    // Interrupt status and mask bits
    localparam int IRQ_EXT   = 0;
    localparam int IRQ_PLL   = 1;
    localparam int IRQ_PRESC = 2;
    localparam int IRQ_W     = 3;

    localparam logic [1:0] BOOT_FLASH  = 2'b00;
    localparam logic [1:0] BOOT_SYSMEM = 2'b01;
    localparam logic [1:0] BOOT_SRAM   = 2'b10;

    // Frequencies in kHz
    localparam int INT_KHZ      = 8000;
    localparam int EXT_MIN_KHZ  = 3000;
    localparam int EXT_MAX_KHZ  = 25000;
    localparam int AHB_MAX_KHZ  = 72000;
    localparam int APB2_MAX_KHZ = 72000;
    localparam int APB1_MAX_KHZ = 36000;
    localparam int PLL_MUL_OFS  = 2;

    // Timing
    localparam int CLK_PERIOD_NS  = 40;
    localparam int CSS_TIMEOUT_NS = 4000;
    localparam int GAP_NS         = 120;
    localparam int BOOT_SETTLE_NS = 200;
    localparam int CSS_CYC  = (CSS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC  = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOOT_CYC = (BOOT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// >>> scs_osc_model.sv
`timescale 1ns/1ps
module scs_osc_model #(
    parameter int KHZ = 25000
) (
    input  wire logic i_run,
    input  wire logic i_slow,
    output logic      o_beat
);
    real  half_ns;
    logic osc_clk;
    int   cnt;

    // Own oscillator, unrelated in phase to the core clock
    initial begin
        half_ns = 500000.0 / KHZ;
        osc_clk = 1'b0;
        o_beat  = 1'b0;
        cnt     = 0;
        #7.3;
        forever #(half_ns) osc_clk = ~osc_clk;
    end

    // Heartbeat every 8 periods, or 64 when slow; a dead source stands still
    always @(posedge osc_clk) begin
        if (i_run) begin
            if (cnt >= (i_slow ? 63 : 7)) begin
                cnt    <= 0;
                o_beat <= ~o_beat;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule // scs_osc_model

// >>> testbench.sv
`timescale 1ns/1ps
module testbench import scs_pkg::*; ;
    logic        i_core_clk, i_nrst, hsel, hwrite, rd_phase, osc_run, osc_slow, ext_beat;
    logic        hreadyout, hresp, sel_int, sel_ext, sel_pll, irq, ext_en, pll_en, pll_ref, prefetch_en;
    logic [1:0]  boot_pins, htrans, flash_wait, boot_sel;
    logic [2:0]  apb1_shift, apb2_shift;
    logic [3:0]  pll_mul, ahb_shift;
    logic [31:0] haddr, hwdata, hrdata, rnd;
    logic [31:0] exp_q[$];
    int          num_errors, tests_run;
    logic [1:0]  boot_tbl [3] = '{2'b00, 2'b01, 2'b11};
    logic [1:0]  boot_exp [3] = '{BOOT_FLASH, BOOT_SYSMEM, BOOT_SRAM};
    logic [7:0]  def_a [6]    = '{A_CTRL, A_PRESC, A_FLASH, A_ISTAT, A_IMASK, 8'h18};
    logic [7:0]  ref_a [5]    = '{A_PRESC, A_CTRL, A_CTRL, A_CTRL, A_CTRL};
    logic [31:0] ref_d [5]    = '{32'h0000_0080, 32'h0000_0003, 32'h0000_0001, 32'h0000_001A, 32'h0000_003E};

    scs_top #(.EXT_KHZ(25000)) dut (
        .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_ext_beat(ext_beat), .i_boot_pins(boot_pins),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
        .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
        .o_hresp(hresp), .o_sel_int(sel_int), .o_sel_ext(sel_ext), .o_sel_pll(sel_pll),
        .o_ext_osc_en(ext_en), .o_pll_en(pll_en), .o_pll_ref_ext(pll_ref), .o_pll_mul(pll_mul),
        .o_ahb_shift(ahb_shift), .o_apb1_shift(apb1_shift), .o_apb2_shift(apb2_shift),
        .o_flash_wait(flash_wait), .o_prefetch_en(prefetch_en), .o_boot_sel(boot_sel), .o_irq(irq)
    );

    scs_osc_model #(.KHZ(25000)) osc (.i_run(osc_run), .i_slow(osc_slow), .o_beat(ext_beat));

    initial begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end

    task automatic print_verdict(input bit hang);
        if (hang) begin
            num_errors++;
            $display("ERROR wait expected %h seen %h", 1, 0);
        end
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_rdy(output int n);
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) print_verdict(1'b1);
    endtask

    // Single word transfer; a read notes its expected data for the monitor
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_core_clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        wait_rdy(n);
        htrans   <= 2'b00;
        hwdata   <= wr ? d : 32'h0;
        rd_phase <= ~wr;
        if (!wr) exp_q.push_back(d);
        wait_rdy(n);
        hsel     <= 1'b0;
        rd_phase <= 1'b0;
        check("data_phase_cycles", wr ? 32'h2 : 32'h1, 32'(n));
    endtask

    // Waits for a source select, counting cycles with no source selected
    task automatic wait_sel(input logic [2:0] tgt);
        int n;
        int z;
        n = 0;
        z = 0;
        while ({sel_int, sel_ext, sel_pll} !== tgt && n < 300) begin
            @(posedge i_core_clk);
            n++;
            if ({sel_int, sel_ext, sel_pll} === 3'b000) z++;
        end
        if ({sel_int, sel_ext, sel_pll} !== tgt) print_verdict(1'b1);
        check("gap_cycles", 32'(GAP_CYC), 32'(z));
    endtask

    task automatic do_reset(input logic [1:0] pins);
        i_nrst    <= 1'b0;
        boot_pins <= pins;
        repeat (8) @(posedge i_core_clk);
        check("sel_in_reset", 32'h4, 32'({sel_int, sel_ext, sel_pll}));
        check("irq_in_reset", 32'h0, 32'(irq));
        i_nrst <= 1'b1;
        repeat (6) @(posedge i_core_clk);
    endtask

    task automatic fail_ext(input logic [31:0] flag);
        osc_run <= 1'b0;
        wait_sel(3'b100);
        bus(1'b0, A_ISTAT, flag);
        osc_run <= 1'b1;
    endtask

    always @(posedge i_core_clk) begin
        if (i_nrst && $countones({sel_int, sel_ext, sel_pll}) > 1) check("sel_onehot", 0, 1);
        if (rd_phase && hreadyout === 1'b1) begin
            check("hresp", 32'h0, 32'(hresp));
            if (exp_q.size() == 0) check("read_queue", 1, 0);
            else check("hrdata", exp_q.pop_front(), hrdata);
        end
    end

    initial begin
        repeat (100000) @(posedge i_core_clk);
        print_verdict(1'b1);
    end

    initial begin
        i_nrst     = 1'b0;
        hsel       = 1'b0;
        hwrite     = 1'b0;
        htrans     = 2'b00;
        haddr      = 32'h0;
        hwdata     = 32'h0;
        rd_phase   = 1'b0;
        boot_pins  = 2'b00;
        osc_run    = 1'b1;
        osc_slow   = 1'b0;
        num_errors = 0;
        tests_run  = 0;
        rnd = $urandom(32'h0935);
        foreach (boot_tbl[i]) begin
            do_reset(boot_tbl[i]);
            check("boot_sel", 32'(boot_exp[i]), 32'(boot_sel));
            boot_pins <= ~boot_tbl[i];
            repeat (4) @(posedge i_core_clk);
            check("boot_hold", 32'(boot_exp[i]), 32'(boot_sel));
        end
        foreach (def_a[i]) bus(1'b0, def_a[i], 32'h0);
        bus(1'b0, A_STAT, 32'h0000_0048);
        $display("test reset and boot done");
        rnd = $urandom();
        bus(1'b1, A_FLASH, rnd);
        bus(1'b1, 8'h18, rnd);
        bus(1'b0, A_FLASH, {29'h0, rnd[2:0]});
        bus(1'b0, 8'h18, 32'h0);
        check("flash_wait", 32'(rnd[1:0]), 32'(flash_wait));
        check("prefetch", 32'(rnd[2]), 32'(prefetch_en));
        rnd = $urandom() % 1024;
        bus(1'b1, A_PRESC, rnd);
        bus(1'b0, A_PRESC, rnd);
        check("shifts", rnd, 32'({apb2_shift, apb1_shift, ahb_shift}));
        bus(1'b1, A_PRESC, 32'h0000_0090);
        bus(1'b1, A_CTRL, 32'h0000_01AA);
        wait_sel(3'b001);
        check("pll_cfg", 32'h0000_001D, 32'({pll_en, pll_mul}));
        $display("test flash and prescaler done");
        foreach (ref_a[i]) begin
            bus(1'b1, ref_a[i], ref_d[i]);
            bus(1'b0, ref_a[i], (ref_a[i] == A_CTRL) ? 32'h0000_01AA : 32'h0000_0090);
            bus(1'b0, A_ISTAT, 32'h0000_0004);
            bus(1'b1, A_ISTAT, 32'h0000_0004);
            bus(1'b0, A_ISTAT, 32'h0);
        end
        check("sel_after_refuse", 32'h1, 32'({sel_int, sel_ext, sel_pll}));
        bus(1'b1, A_CTRL, 32'h0);
        wait_sel(3'b100);
        $display("test limits done");
        osc_slow <= 1'b1;
        bus(1'b1, A_CTRL, 32'h0000_0005);
        wait_sel(3'b010);
        repeat (200) @(posedge i_core_clk);
        check("ext_kept", 32'h2, 32'({sel_int, sel_ext, sel_pll}));
        fail_ext(32'h0000_0001);
        check("irq_masked", 32'h0, 32'(irq));
        bus(1'b0, A_CTRL, 32'h0000_0004);
        repeat (20) @(posedge i_core_clk);
        bus(1'b0, A_ISTAT, 32'h0000_0001);
        bus(1'b1, A_IMASK, 32'h0000_0003);
        repeat (2) @(posedge i_core_clk);
        check("irq_unmasked", 32'h1, 32'(irq));
        bus(1'b1, A_ISTAT, 32'h0000_0001);
        repeat (2) @(posedge i_core_clk);
        check("irq_cleared", 32'h0, 32'(irq));
        osc_slow <= 1'b0;
        bus(1'b1, A_CTRL, 32'h0000_0005);
        wait_sel(3'b010);
        fail_ext(32'h0000_0001);
        check("irq_ext", 32'h1, 32'(irq));
        bus(1'b1, A_ISTAT, 32'h0000_0001);
        $display("test external failure done");
        bus(1'b1, A_CTRL, 32'h0000_001E);
        wait_sel(3'b001);
        check("pll_ref", 32'h7, 32'({ext_en, pll_en, pll_ref}));
        fail_ext(32'h0000_0002);
        check("irq_pll", 32'h1, 32'(irq));
        bus(1'b0, A_CTRL, 32'h0000_001C);
        bus(1'b1, A_ISTAT, 32'h0000_0002);
        bus(1'b0, A_ISTAT, 32'h0);
        repeat (2) @(posedge i_core_clk);
        check("irq_end", 32'h0, 32'(irq));
        $display("test pll failure done");
        print_verdict(1'b0);
    end
endmodule // testbench
